// >>> uart_status_pkg.sv
// Contract
// - 6-8 bit chars: stop 9/16..1, 1 9/16..2
// - 5 bit chars: stop 1 1/16..2
// - External 1x clock: top bit selects 1/2
// - Framing checked at first stop centre only
// - Status bits: break,fe,pe,oe,temt,trdy,full,rdy
// - Break is zero char, one FIFO slot
// - After break, wait two bit-clock ticks of mark to reload
// - Break start and end pulse change flag
// - Mid-character break detected only if the whole character reads zero
// - Character mode: errors of head character
// - Block mode: errors sticky until reset command
// - Parity error only when parity enabled
// - Overrun when FIFO full and shifter waits
// - Overrun always sticky until reset command
// - Tx empty after last stop, idle
// - Tx ready clears on write, sets on move
// - Writes while disabled never transmitted
// - FIFO full at three, clears on read
// - Waiting shifter char keeps full set
// - Error mode bit: char 0, block 1
// - Rx ready set on load, clear empty
package uart_status_pkg;
  localparam int        FIFO_DEPTH   = 3;
  localparam int        OVS          = 16;
  localparam logic [3:0] ST_INIT     = 4'h0;
  localparam logic [1:0] ADDR_MODE   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_DATA   = 2'h2;
  localparam logic [1:0] ADDR_CMD    = 2'h3;
  localparam int        B_CMD_TXEN  = 0;
  localparam int        B_CMD_TXDIS = 1;
  localparam int        B_CMD_RSTE  = 2;
  // Stop lengths in bit-clock ticks
  localparam logic [5:0] STOP_BASE6  = 6'h09;
  localparam logic [5:0] STOP_BASE5  = 6'h11;
  localparam logic [5:0] STOP_STEP6  = 6'h10;
  localparam logic [5:0] STOP_STEP5  = 6'h08;
  localparam logic [5:0] STOP_ONE    = 6'h01;
  localparam logic [5:0] STOP_TWO    = 6'h02;

  typedef struct packed {
    logic       ext_1x;
    logic       error_block;
    logic [1:0] parity_mode;
    logic       parity_odd;
    logic [1:0] char_len;
    logic [3:0] stop_len;
  } mode_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } rx_entry_t;
endpackage : uart_status_pkg

// >>> uart_channel_status.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module uart_channel_status
  import uart_status_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [1:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [15:0]     rdata,
  // Bit clocks, serial lines
  input  wire logic       bit_tick,
  input  wire logic       serial_in,
  output logic            serial_out,
  // Break change event
  output logic            break_change
);
  initial begin
    if (DEPTH != 3) $error("DEPTH must be 3");
  end

  logic [15:0] mode_reg;
  mode_t       mode;
  assign mode = mode_t'(mode_reg[10:0]);

  // Input synchronisers
  logic [1:0] rx_s, tk_s;
  logic       tk_d;
  always_ff @(posedge sys_clk) begin
    rx_s <= {rx_s[0], serial_in};
    tk_s <= {tk_s[0], bit_tick};
    tk_d <= tk_s[1];
  end
  wire tick = tk_s[1] & ~tk_d;
  wire rxd  = rx_s[1];

  wire cmd_wr  = wr && addr == ADDR_CMD;
  wire mode_wr = wr && addr == ADDR_MODE;
  wire data_wr = wr && addr == ADDR_DATA;
  wire data_rd = rd && addr == ADDR_DATA;
  wire tx_en_c  = cmd_wr && wdata[B_CMD_TXEN];
  wire tx_dis_c = cmd_wr && wdata[B_CMD_TXDIS];
  wire rst_err  = cmd_wr && wdata[B_CMD_RSTE];

  always_ff @(posedge sys_clk) begin
    if (rst) mode_reg <= '0;
    else if (mode_wr) mode_reg <= wdata;
  end

  function automatic logic [3:0] data_bits(input logic [1:0] cl);
    return 4'(5 + cl);
  endfunction

  // Transmitter
  typedef enum logic [1:0] {TX_DATA, TX_PARITY, TX_STOP} tx_phase_t;
  logic       tx_en_reg, thr_full_reg, tsr_busy_reg, temt_reg;
  logic [7:0] thr_reg, tsr_reg;
  logic [3:0] tx_bit_reg, tx_sub_reg;
  logic [5:0] stop_cnt_reg;
  tx_phase_t  tx_ph_reg;
  logic       tx_par_reg;
  wire        with_par = ~mode.parity_mode[1];
  wire        tx_par_bit = mode.parity_mode == 2'h1 ? mode.parity_odd : tx_par_reg;
  // Stop length counted in ticks of the bit clock
  wire [5:0]  stop_len =
    mode.ext_1x ? (mode.stop_len[3] ? STOP_TWO : STOP_ONE) :
    (mode.char_len == 2'h0 ? STOP_BASE5 + 6'(mode.stop_len[2:0]) +
      (mode.stop_len[3] ? STOP_STEP5 : 6'h00)
    : STOP_BASE6 + 6'(mode.stop_len[2:0]) +
      (mode.stop_len[3] ? STOP_STEP6 : 6'h00));
  wire tx_step  = tick && (mode.ext_1x || tx_sub_reg == 4'(OVS - 1));
  wire tx_stop  = tsr_busy_reg && tx_ph_reg == TX_STOP && tick;
  wire stop_end = tx_stop && stop_cnt_reg + 6'h01 == stop_len;
  // Loads only on a tick so the start bit is a full bit time
  wire tx_load  = tick && tx_en_reg && thr_full_reg && !data_wr && !tx_dis_c &&
                  (!tsr_busy_reg || stop_end);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_en_reg <= 1'b0; thr_full_reg <= 1'b0; tsr_busy_reg <= 1'b0;
      temt_reg <= 1'b0; thr_reg <= '0; tsr_reg <= '0; tx_bit_reg <= '0;
      tx_sub_reg <= '0; stop_cnt_reg <= '0; tx_ph_reg <= TX_DATA;
      tx_par_reg <= 1'b0; serial_out <= 1'b1;
    end else begin
      if (tick) tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_en_c) tx_en_reg <= 1'b1;
      if (tx_dis_c) begin
        tx_en_reg <= 1'b0;
        thr_full_reg <= 1'b1; // ready clear on disable
        temt_reg <= 1'b0;
      end else if (tx_en_c && !tx_en_reg) thr_full_reg <= 1'b0;
      if (data_wr) begin
        thr_reg <= wdata[7:0];
        thr_full_reg <= 1'b1;
        temt_reg <= 1'b0;
      end
      if (tx_load) begin
        tsr_reg <= thr_reg;
        thr_full_reg <= 1'b0;
        tsr_busy_reg <= 1'b1;
        tx_ph_reg <= TX_DATA;
        tx_bit_reg <= '0;
        tx_sub_reg <= '0;
        tx_par_reg <= mode.parity_odd;
        serial_out <= 1'b0;
      end else if (stop_end) begin
        tsr_busy_reg <= 1'b0;
        if (!thr_full_reg && !data_wr) temt_reg <= 1'b1;
      end else if (tx_stop) begin
        stop_cnt_reg <= stop_cnt_reg + 6'h01;
      end else if (tsr_busy_reg && tx_step) begin
        case (tx_ph_reg)
          TX_DATA: begin
            if (tx_bit_reg == data_bits(mode.char_len)) begin
              serial_out <= with_par ? tx_par_bit : 1'b1;
              tx_ph_reg <= with_par ? TX_PARITY : TX_STOP;
              stop_cnt_reg <= '0;
            end else begin
              serial_out <= tsr_reg[tx_bit_reg[2:0]];
              tx_par_reg <= tx_par_reg ^ tsr_reg[tx_bit_reg[2:0]];
              tx_bit_reg <= tx_bit_reg + 4'h1;
            end
          end
          TX_PARITY: begin
            serial_out <= 1'b1;
            tx_ph_reg <= TX_STOP;
            stop_cnt_reg <= '0;
          end
          default: tx_ph_reg <= TX_STOP;
        endcase
      end
    end
  end

  // Receiver
  rx_entry_t fifo_mem [DEPTH];
  logic [1:0] wp_reg, rp_reg, cnt_reg;
  rx_entry_t  rsr_reg;
  logic       rsr_wait_reg, full_reg, oe_reg, brk_hold_reg;
  logic       rx_busy_reg;
  logic [3:0] rx_sub_reg, rx_bit_reg;
  logic       rx_par_reg, rx_pbit_reg, rxd_d_reg;
  rx_entry_t  wait_reg;
  logic [1:0] mark_cnt_reg;
  logic       bk_acc_reg, fe_acc_reg, pe_acc_reg;

  wire rx_sample = tick && (mode.ext_1x || rx_sub_reg == 4'(OVS / 2 - 1));
  wire [3:0] last_bit = data_bits(mode.char_len) + (with_par ? 4'h1 : 4'h0);
  wire stop_smp = rx_busy_reg && rx_sample && rx_bit_reg == last_bit + 4'h1;
  wire par_bad = mode.parity_mode == 2'h1 ? (rx_pbit_reg != mode.parity_odd)
                                           : (rx_par_reg != mode.parity_odd);
  wire is_break = stop_smp && !rxd && rsr_reg.data == 8'h00 && !rx_par_reg;
  wire fifo_pop  = data_rd && cnt_reg != 2'h0;
  wire char_done = stop_smp && !brk_hold_reg;
  wire can_push  = cnt_reg != 2'(DEPTH) || fifo_pop;
  wire push = (rsr_wait_reg || char_done) && can_push;
  rx_entry_t new_ent;
  assign new_ent = '{brk: is_break, fe: !rxd && !is_break,
                     pe: with_par && par_bad, data: rsr_reg.data};
  rx_entry_t head;
  assign head = fifo_mem[rp_reg];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_reg <= '0; rp_reg <= '0; cnt_reg <= '0; rsr_reg <= '0;
      rsr_wait_reg <= 1'b0; full_reg <= 1'b0; oe_reg <= 1'b0;
      brk_hold_reg <= 1'b0; rx_busy_reg <= 1'b0; rx_sub_reg <= '0;
      rx_bit_reg <= '0; rx_par_reg <= 1'b0; mark_cnt_reg <= '0;
      rx_pbit_reg <= 1'b0; rxd_d_reg <= 1'b1; wait_reg <= '0;
      bk_acc_reg <= 1'b0; fe_acc_reg <= 1'b0; pe_acc_reg <= 1'b0;
      break_change <= 1'b0;
      for (int i = 0; i < DEPTH; i++) fifo_mem[i] <= '0;
    end else begin
      break_change <= 1'b0;
      if (tick) rx_sub_reg <= rx_sub_reg + 4'h1;
      rxd_d_reg <= rxd;
      // Start only on a falling edge, not on a low stop level
      if (!rx_busy_reg && !brk_hold_reg && rxd_d_reg && !rxd) begin
        rx_busy_reg <= 1'b1; rx_bit_reg <= '0; rx_sub_reg <= '0;
        rx_par_reg <= 1'b0; rsr_reg <= '0;
      end else if (rx_busy_reg && rx_sample) begin
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == last_bit) rx_pbit_reg <= rxd;
        if (rx_bit_reg != 4'h0 && rx_bit_reg <= last_bit) begin
          rx_par_reg <= rx_par_reg ^ rxd;
          if (rx_bit_reg <= data_bits(mode.char_len))
            rsr_reg.data[3'(rx_bit_reg - 4'h1)] <= rxd;
        end
        if (stop_smp) rx_busy_reg <= 1'b0;
      end
      if (is_break && !brk_hold_reg) begin
        brk_hold_reg <= 1'b1; break_change <= 1'b1; mark_cnt_reg <= '0;
      end else if (brk_hold_reg) begin
        if (!rxd) mark_cnt_reg <= '0;
        else if (tick) mark_cnt_reg <= mark_cnt_reg + 2'h1;
        if (rxd && tick && mark_cnt_reg == 2'h1) begin
          brk_hold_reg <= 1'b0; break_change <= 1'b1;
        end
      end
      // Waiting character kept apart from the shifter
      if (char_done && (rsr_wait_reg || !can_push)) begin
        if (rsr_wait_reg && !can_push) oe_reg <= 1'b1;
        wait_reg <= new_ent;
        rsr_wait_reg <= 1'b1;
      end else if (push && rsr_wait_reg) rsr_wait_reg <= 1'b0;
      if (push) begin
        fifo_mem[wp_reg] <= rsr_wait_reg ? wait_reg : new_ent;
        wp_reg <= wp_reg == 2'(DEPTH - 1) ? 2'h0 : wp_reg + 2'h1;
      end
      if (fifo_pop) rp_reg <= rp_reg == 2'(DEPTH - 1) ? 2'h0 : rp_reg + 2'h1;
      cnt_reg <= cnt_reg + (push ? 2'h1 : 2'h0) - (fifo_pop ? 2'h1 : 2'h0);
      if (push && cnt_reg + 2'h1 - (fifo_pop ? 2'h1 : 2'h0) == 2'(DEPTH))
        full_reg <= 1'b1;
      else if (fifo_pop && !rsr_wait_reg) full_reg <= 1'b0;
      if (fifo_pop) begin
        bk_acc_reg <= bk_acc_reg | head.brk;
        fe_acc_reg <= fe_acc_reg | head.fe;
        pe_acc_reg <= pe_acc_reg | head.pe;
      end
      if (rst_err) begin
        bk_acc_reg <= 1'b0; fe_acc_reg <= 1'b0; pe_acc_reg <= 1'b0;
        if (!(char_done && !can_push && rsr_wait_reg)) oe_reg <= 1'b0;
      end
    end
  end

  wire hv = cnt_reg != 2'h0;
  wire [2:0] err_now = hv ? {head.brk, head.fe, head.pe} : 3'h0;
  wire [2:0] err_bits = mode.error_block ?
    err_now | {bk_acc_reg, fe_acc_reg, pe_acc_reg} : err_now;
  wire [7:0] status = {err_bits, oe_reg, temt_reg,
                       tx_en_reg && !thr_full_reg, full_reg, hv};

  // Read data; status reads have no side effect
  always_ff @(posedge sys_clk) begin
    if (rst) rdata <= '0;
    else if (rd) begin
      case (addr)
        ADDR_MODE:   rdata <= mode_reg;
        ADDR_STATUS: rdata <= {8'h00, status};
        ADDR_DATA:   rdata <= {8'h00, head.data};
        default:     rdata <= '0;
      endcase
    end else rdata <= '0;
  end
endmodule : uart_channel_status

// >>> uart_status_chk.sv
`timescale 1ns/1ps
module uart_status_chk
  import uart_status_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock, reset, register port
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [1:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Serial side
  input wire logic        bit_tick,
  input wire logic        serial_in,
  input wire logic        serial_out,
  input wire logic        break_change
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       on_reg, new_reg, brk_reg, tk_reg, ovr_reg;
  logic [9:0] lo_reg, hi_reg;
  wire        st_rd = rd && addr == ADDR_STATUS;
  wire        cmd   = wr && addr == ADDR_CMD;
  wire        tk    = bit_tick && !tk_reg;
  always_ff @(posedge sys_clk) begin
    tk_reg <= bit_tick;
    if (rst) begin
      {on_reg, new_reg, brk_reg, ovr_reg, lo_reg, hi_reg} <= '0;
    end else begin
      // Enabled with nothing written since
      if (cmd && wdata[B_CMD_TXDIS]) {on_reg, new_reg} <= 2'b00;
      else if (cmd && wdata[B_CMD_TXEN] && !on_reg) {on_reg, new_reg} <= 2'b11;
      else if (wr && addr == ADDR_DATA) new_reg <= 1'b0;
      if (cmd && wdata[B_CMD_RSTE]) ovr_reg <= 1'b0;
      else if ($past(st_rd) && rdata[4]) ovr_reg <= 1'b1;
      brk_reg <= brk_reg ^ break_change;
      lo_reg  <= serial_in ? 10'h000 : lo_reg + {9'h000, tk && lo_reg != 10'h3FF};
      hi_reg  <= !serial_in ? 10'h000 : hi_reg + {9'h000, tk && hi_reg != 10'h3FF};
    end
  end
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata not zero");
  AST_STATUS_UPPER: assert property ($past(st_rd) |-> rdata[15:8] == 8'h00) else $error("status upper");
  AST_BRK_PULSE: assert property (break_change |=> !break_change) else $error("break pulse long");
  AST_BRK_START: assert property (break_change && !brk_reg |-> lo_reg >= 10'd128) else $error("early break");
  AST_BRK_END: assert property (break_change && brk_reg |-> serial_in && hi_reg >= 10'd2) else $error("break end");
  AST_READY_FRESH: assert property ($past(st_rd) && $past(new_reg) |-> rdata[2]) else $error("tx ready");
  AST_TX_OFF: assert property ($past(st_rd) && !$past(on_reg) |-> !rdata[2]) else $error("ready off");
  AST_OVR_STICKY: assert property ($past(st_rd) && $past(ovr_reg) |-> rdata[4]) else $error("overrun lost");
endmodule : uart_status_chk

bind uart_channel_status uart_status_chk #(.DEPTH(DEPTH)) chk_u (.sys_clk(sys_clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bit_tick(bit_tick), .serial_in(serial_in),
  .serial_out(serial_out), .break_change(break_change));

// >>> uart_far_end.sv
`timescale 1ns/1ps
module uart_far_end (
  // Clock and serial lines
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output logic      serial_in
);
  initial serial_in = 1'b1;
  // Start, eight bits LSB first, stop level held 1+low bits
  task automatic send(input logic [7:0] d, input int bc, input logic stp, input int low);
    serial_in <= 1'b0;
    repeat (bc) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      serial_in <= d[i];
      repeat (bc) @(posedge sys_clk);
    end
    serial_in <= stp;
    repeat (bc * (1 + low)) @(posedge sys_clk);
    serial_in <= 1'b1;
    repeat (bc * 2) @(posedge sys_clk);
  endtask : send
  // Sample a character, then time its stop up to the next start
  task automatic grab(input int n, input int bc, output logic [7:0] d, output int gap);
    d = 8'h00;
    @(negedge serial_out);
    repeat (bc + bc / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      d[i] = serial_out;
      repeat (bc) @(posedge sys_clk);
    end
    for (gap = bc / 2; serial_out; gap++) @(posedge sys_clk);
  endtask : grab
endmodule : uart_far_end

// >>> testbench.sv
`timescale 1ns/1ps
module testbench
  import uart_status_pkg::*;
;
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
  logic        sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bit_tick = 1'b0, ovr = 1'b0, wt = 1'b0, blk = 1'b0;
  logic [1:0]  addr = 2'h0, acc = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic        serial_in, serial_out, break_change;
  logic [7:0]  got;
  logic [9:0]  q[$], wv;
  logic [6:0]  cs[8] = '{7'h30, 7'h37, 7'h38, 7'h3F, 7'h00, 7'h0F, 7'h47, 7'h78};
  int          n_fail = 0, n_checks = 0, n_brk = 0, n_fall = 0, gap, bc;
  always #5 sys_clk = ~sys_clk;
  always #40 bit_tick = ~bit_tick;
  always @(posedge sys_clk) n_brk <= n_brk + int'(break_change === 1'b1);
  always @(negedge serial_out) n_fall++;
  uart_channel_status dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bit_tick(bit_tick), .serial_in(serial_in), .serial_out(serial_out), .break_change(break_change));
  uart_far_end far_u (.sys_clk(sys_clk), .serial_out(serial_out), .serial_in(serial_in));
  task automatic wrt(input logic [1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdr(input logic [1:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
  endtask : rdr
  task automatic chk_st(input logic [7:0] m, input logic [1:0] tx);
    logic [1:0] h;
    h = (q.size() > 0 ? q[0][9:8] : 2'b00) | acc;
    rdr(ADDR_STATUS, v);
    `CHK("status", {h, 1'b0, ovr, tx, q.size() == 3, q.size() > 0} & m, v[7:0] & m)
  endtask : chk_st
  task automatic rx(input logic [7:0] d, input logic stp, input int low);
    far_u.send(d, 128, stp, low);
    if (q.size() < 3) q.push_back({low > 0, !stp, d});
    else begin
      ovr = ovr | wt;
      wt = 1'b1;
      wv = {low > 0, !stp, d};
    end
  endtask : rx
  task automatic pop;
    rdr(ADDR_DATA, v);
    `CHK("rx_data", q[0][7:0], v[7:0])
    acc = acc | (q[0][9:8] & {2{blk}});
    void'(q.pop_front());
    if (wt) q.push_back(wv);
    wt = 1'b0;
  endtask : pop
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  function automatic int stop_exp(input logic [6:0] c);
    if (c[6]) return c[3] ? 2 : 1;
    return (c[5:4] == 2'b00) ? 17 + c[3:0] : 9 + c[3:0] + (c[3] ? 8 : 0);
  endfunction : stop_exp
  initial begin
    #1000000;
    n_fail++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hBC8B));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wrt(ADDR_MODE, 16'h0130);
    wrt(ADDR_DATA, 16'h00A5);
    chk_st(8'h04, 2'b00);
    wrt(ADDR_CMD, 16'h0001);
    chk_st(8'h04, 2'b01);
    repeat (1600) @(posedge sys_clk);
    `CHK("tx_starts", 0, n_fall)
    foreach (cs[i]) begin
      bc = cs[i][6] ? 8 : 128;
      wrt(ADDR_MODE, {5'h00, cs[i][6], 4'h4, cs[i][5:0]});
      v = 16'($urandom());
      fork
        far_u.grab(cs[i][5:4] + 5, bc, got, gap);
        begin
          wrt(ADDR_DATA, v);
          repeat (16) @(posedge sys_clk);
          wrt(ADDR_DATA, ~v);
        end
      join
      `CHK("tx_data", v[7:0] & (8'hFF >> (2'd3 - cs[i][5:4])), got)
      `CHK("stop_ticks", stop_exp(cs[i]), (gap + 4) / 8)
      repeat (12 * bc) @(posedge sys_clk);
    end
    chk_st(8'h0C, 2'b11);
    wrt(ADDR_MODE, 16'h0130);
    for (int i = 0; i < 5; i++) begin
      rx(8'($urandom()), i != 1, 0);
      chk_st(8'hF3, 2'b00);
    end
    repeat (4) begin
      pop();
      chk_st(8'hF3, 2'b00);
    end
    wrt(ADDR_CMD, 16'h0004);
    ovr = 1'b0;
    wrt(ADDR_MODE, 16'h0330);
    blk = 1'b1;
    rx(8'h3C, 1'b0, 0);
    rx(8'hC3, 1'b1, 0);
    pop();
    pop();
    chk_st(8'hF3, 2'b00);
    wrt(ADDR_CMD, 16'h0004);
    acc = 2'b00;
    chk_st(8'hF3, 2'b00);
    rx(8'h00, 1'b0, 10);
    `CHK("break_events", 2, n_brk)
    chk_st(8'hB3, 2'b00);
    pop();
    end_sim();
  end
endmodule : testbench
